// *** design/pcd_top.sv ***
// Pin-change interrupt block: per-pin edge detectors, sticky flags,
// master enable, interrupt and wake request, Wishbone register slave.
// Assumes port pins and SLEEP_I are synchronous to REF_CLK_I.
`timescale 1ns/1ps
module pcd_top
   import pcd_pkg::*;
#(
   parameter int W = PCD_PORT_W
)
(
   input wire logic REF_CLK_I,                   // 100 MHz system clock
   input wire logic RESET_I,                     // Sync reset, active high
   input wire logic [W-1:0] PORT_I,              // Monitored port pins
   input wire logic SLEEP_I,                     // Core is asleep
   input wire logic WB_CYC_I,                    // Bus cycle
   input wire logic WB_STB_I,                    // Bus strobe
   input wire logic WB_WE_I,                     // Write enable
   input wire logic [PCD_ADR_W-1:0] WB_ADR_I,    // Byte address
   input wire logic [PCD_SEL_W-1:0] WB_SEL_I,    // Byte selects
   input wire logic [PCD_DAT_W-1:0] WB_DAT_I,    // Write data
   output logic [PCD_DAT_W-1:0] WB_DAT_O,        // Read data
   output logic WB_ACK_O,                        // Acknowledge
   output logic IRQ_O,                           // Interrupt level
   output logic WAKE_O                           // Wake request level
);

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   typedef struct packed {
      logic me;
      logic [W-1:0] rise_en;
      logic [W-1:0] fall_en;
      logic [W-1:0] mask;
      logic ack;
      logic [PCD_DAT_W-1:0] dat;
      logic irq;
      logic wake;
   } pcd_top_s;

   pcd_top_s s_q, s_d;

   logic [W-1:0] rise_raw;
   logic [W-1:0] fall_raw;
   logic [W-1:0] edge_ev;
   logic [W-1:0] flag_q;
   logic [W-1:0] flag_d;
   logic [W-1:0] flag_clr;
   logic [W-1:0] stat_q;
   logic [W-1:0] stat_d;
   logic [W-1:0] stat_clr;
   logic [W-1:0] pins_q;
   logic req;
   logic wr_fire;
   logic lane0_wr;
   logic [W-1:0] wdat;
   logic summary;
   logic [PCD_DAT_W-1:0] rdat;

   // -------------------------------------------------------------------
   // Edge detection, one detector pair per pin
   // -------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < W; gi++) begin : g_pin
         pcd_edge_det u_det (
            .clk_i(REF_CLK_I),
            .rst_i(RESET_I),
            .pin_i(PORT_I[gi]),
            .rise_en_i(s_q.rise_en[gi]),
            .fall_en_i(s_q.fall_en[gi]),
            .rise_o(rise_raw[gi]),
            .fall_o(fall_raw[gi]),
            .event_o(edge_ev[gi])
         );
      end
   endgenerate

   // -------------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------------
   // Writes land at the edge that the master sees ack, never earlier
   assign req = WB_CYC_I & WB_STB_I;
   assign wr_fire = req & WB_WE_I & s_q.ack;
   assign lane0_wr = wr_fire & WB_SEL_I[PCD_LANE0];
   assign wdat = WB_DAT_I[W-1:0];

   // Pin flags clear on written zeros; other bits untouched
   assign flag_clr = (lane0_wr && WB_ADR_I == PCD_FLAG_OFF) ?
                     ~wdat : '0;
   // Interrupt status clears on written ones
   assign stat_clr = (lane0_wr && WB_ADR_I == PCD_STAT_OFF) ? wdat : '0;

   // -------------------------------------------------------------------
   // Flags: pin flags and interrupt status
   // -------------------------------------------------------------------
   // Flags set regardless of the master enable
   pcd_sticky #(.W(W)) u_flag (
      .clk_i(REF_CLK_I),
      .rst_i(RESET_I),
      .set_i(edge_ev),
      .clr_i(flag_clr),
      .q_o(flag_q),
      .d_o(flag_d)
   );

   pcd_sticky #(.W(W)) u_stat (
      .clk_i(REF_CLK_I),
      .rst_i(RESET_I),
      .set_i(edge_ev),
      .clr_i(stat_clr),
      .q_o(stat_q),
      .d_o(stat_d)
   );

   assign summary = |flag_q;

   // Live pin levels taken straight from PORT_I, unregistered, for software polling
   always_comb begin
      pins_q = '0;
      for (int i = 0; i < W; i++) begin
         pins_q[i] = PORT_I[i];
      end
   end

   // -------------------------------------------------------------------
   // Read mux
   // -------------------------------------------------------------------
   always_comb begin
      rdat = PCD_DAT_RST;
      case (WB_ADR_I)
         PCD_CTRL_OFF: begin
            rdat[PCD_ME_BIT] = s_q.me;
            rdat[PCD_SUM_BIT] = summary;
         end
         PCD_RISE_OFF: rdat[W-1:0] = s_q.rise_en;
         PCD_FALL_OFF: rdat[W-1:0] = s_q.fall_en;
         PCD_FLAG_OFF: rdat[W-1:0] = flag_q;
         PCD_PINS_OFF: rdat[W-1:0] = pins_q;
         PCD_STAT_OFF: rdat[W-1:0] = stat_q;
         PCD_MASK_OFF: rdat[W-1:0] = s_q.mask;
         // Unmapped addresses are acknowledged and read as zero
         default: rdat = PCD_DAT_RST;
      endcase
   end

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      // One-cycle ack; drops the cycle after it was given
      s_d.ack = req & ~s_q.ack;
      s_d.dat = (req & ~s_q.ack & ~WB_WE_I) ? rdat : PCD_DAT_RST;
      if (lane0_wr) begin
         case (WB_ADR_I)
            PCD_CTRL_OFF: s_d.me = WB_DAT_I[PCD_ME_BIT];
            PCD_RISE_OFF: s_d.rise_en = wdat;
            PCD_FALL_OFF: s_d.fall_en = wdat;
            PCD_MASK_OFF: s_d.mask = wdat;
            default: s_d.me = s_q.me;
         endcase
      end
      // Interrupt only while master enabled; a new event in the same
      // cycle as a status clear still raises it
      s_d.irq = s_q.me & |(stat_d & s_q.mask);
      // Wake comes from the same edge that sets the flag, so the flag
      // is readable before the core runs its first instruction
      s_d.wake = SLEEP_I & s_q.me & |flag_d;
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign WB_ACK_O = s_q.ack;
   assign WB_DAT_O = s_q.dat;
   assign IRQ_O = s_q.irq;
   assign WAKE_O = s_q.wake;

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (RESET_I);

   property p_rise_sets;
      logic [W-1:0] v;
      (|(rise_raw & s_q.rise_en), v = rise_raw & s_q.rise_en)
         |=> ((flag_q & v) == v);
   endproperty
   a_rise_sets: assert property (p_rise_sets)
      else $error("enabled rising edge did not set its flag");

   property p_fall_sets;
      logic [W-1:0] v;
      (|(fall_raw & s_q.fall_en), v = fall_raw & s_q.fall_en)
         |=> ((flag_q & v) == v);
   endproperty
   a_fall_sets: assert property (p_fall_sets)
      else $error("enabled falling edge did not set its flag");

   property p_only_enabled;
      ((flag_q & ~$past(flag_q)) &
       ~$past((rise_raw & s_q.rise_en) | (fall_raw & s_q.fall_en))) == '0;
   endproperty
   a_only_enabled: assert property (p_only_enabled)
      else $error("flag set without an enabled edge");

   property p_sample;
      |rise_raw |-> ((rise_raw & $past(PORT_I, 1) & ~$past(PORT_I, 2))
                     == rise_raw);
   endproperty
   a_sample: assert property (p_sample)
      else $error("rising edge reported without two matching samples");

   property p_sticky;
      ((~flag_q & $past(flag_q)) &
       ~$past((lane0_wr && WB_ADR_I == PCD_FLAG_OFF) ? ~wdat : '0)) == '0;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("flag dropped without a zero written to it");

   property p_set_wins;
      logic [W-1:0] v;
      (|(edge_ev & flag_clr), v = edge_ev & flag_clr)
         |=> ((flag_q & v) == v);
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("edge lost during flag clear");

   property p_summary;
      WB_ACK_O && !$past(WB_WE_I) && $past(WB_ADR_I) == PCD_CTRL_OFF
         |-> WB_DAT_O[PCD_SUM_BIT] == $past(|flag_q);
   endproperty
   a_summary: assert property (p_summary)
      else $error("summary flag does not follow the pin flags");

   property p_irq_gate;
      IRQ_O |-> $past(s_q.me);
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("interrupt raised while master enable clear");

   property p_irq_raise;
      s_q.me && |(edge_ev & s_q.mask) |=> IRQ_O;
   endproperty
   a_irq_raise: assert property (p_irq_raise)
      else $error("enabled event did not raise the interrupt");

   property p_wake;
      SLEEP_I && s_q.me && |edge_ev |=> WAKE_O;
   endproperty
   a_wake: assert property (p_wake)
      else $error("change event in sleep did not wake");

   property p_flag_first;
      WAKE_O |-> |flag_q;
   endproperty
   a_flag_first: assert property (p_flag_first)
      else $error("wake asserted before flag recorded");

   property p_reset_clear;
      $past(RESET_I) |-> (s_q.rise_en == '0 && s_q.fall_en == '0
                          && flag_q == '0);
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("enables or flags not cleared by reset");

   property p_ack_pulse;
      WB_ACK_O |=> !WB_ACK_O;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack held longer than one cycle");

   // Status follows the same events as the flags, master enable or not
   property p_event_sets;
      logic [W-1:0] v;
      (|edge_ev, v = edge_ev)
         |=> ((flag_q & v) == v && (stat_q & v) == v);
   endproperty
   a_event_sets: assert property (p_event_sets)
      else $error("enabled edge did not set flag and status");

   property p_stat_sticky;
      ((~stat_q & $past(stat_q)) & ~$past(stat_clr)) == '0;
   endproperty
   a_stat_sticky: assert property (p_stat_sticky)
      else $error("status dropped without a one written to it");

   property p_irq_off;
      !s_q.me |=> !IRQ_O;
   endproperty
   a_irq_off: assert property (p_irq_off)
      else $error("interrupt raised after master enable was clear");

   property p_wake_gate;
      WAKE_O |-> $past(SLEEP_I) && $past(s_q.me);
   endproperty
   a_wake_gate: assert property (p_wake_gate)
      else $error("wake raised outside sleep or while disabled");

   property p_rise_write;
      lane0_wr && WB_ADR_I == PCD_RISE_OFF
         |=> s_q.rise_en == $past(wdat);
   endproperty
   a_rise_write: assert property (p_rise_write)
      else $error("rising enable write did not land");

   property p_fall_write;
      lane0_wr && WB_ADR_I == PCD_FALL_OFF
         |=> s_q.fall_en == $past(wdat);
   endproperty
   a_fall_write: assert property (p_fall_write)
      else $error("falling enable write did not land");

   property p_me_write;
      lane0_wr && WB_ADR_I == PCD_CTRL_OFF
         |=> s_q.me == $past(WB_DAT_I[PCD_ME_BIT]);
   endproperty
   a_me_write: assert property (p_me_write)
      else $error("master enable write did not land");

   property p_ack_answer;
      req && !WB_ACK_O |=> WB_ACK_O;
   endproperty
   a_ack_answer: assert property (p_ack_answer)
      else $error("request not acknowledged in the next cycle");

   property p_dat_idle;
      !WB_ACK_O |-> WB_DAT_O == PCD_DAT_RST;
   endproperty
   a_dat_idle: assert property (p_dat_idle)
      else $error("read data not zero outside ack");

   // A pin held high through reset must not look like a rising edge
   property p_prime;
      $past(RESET_I) || $past(RESET_I, 2)
         |-> rise_raw == '0 && fall_raw == '0;
   endproperty
   a_prime: assert property (p_prime)
      else $error("edge reported before two samples after reset");

   // Main scenarios
   c_both_edges: cover property (|(rise_raw & s_q.rise_en & s_q.fall_en)
                                 ##[1:20] |(fall_raw & s_q.fall_en));
   c_set_wins: cover property (|(edge_ev & flag_clr));
   c_wake: cover property (SLEEP_I ##1 WAKE_O);
   c_irq: cover property (!IRQ_O ##1 IRQ_O);

endmodule // pcd_top

// *** design/pcd_pkg.sv ***
// Constants for the port pin-change interrupt block: register map,
// control bit positions and reset values.
// Assumes a 32-bit classic Wishbone master with byte addressing.
package pcd_pkg;

   // -------------------------------------------------------------------
   // Bus and port geometry
   // -------------------------------------------------------------------
   localparam int PCD_ADR_W = 8;
   localparam int PCD_DAT_W = 32;
   localparam int PCD_SEL_W = 4;
   localparam int PCD_PORT_W = 8;

   // -------------------------------------------------------------------
   // Register byte offsets
   // -------------------------------------------------------------------
   localparam logic [PCD_ADR_W-1:0] PCD_CTRL_OFF = 8'h00;
   localparam logic [PCD_ADR_W-1:0] PCD_RISE_OFF = 8'h04;
   localparam logic [PCD_ADR_W-1:0] PCD_FALL_OFF = 8'h08;
   localparam logic [PCD_ADR_W-1:0] PCD_FLAG_OFF = 8'h0C;
   localparam logic [PCD_ADR_W-1:0] PCD_PINS_OFF = 8'h10;
   localparam logic [PCD_ADR_W-1:0] PCD_STAT_OFF = 8'h14;
   localparam logic [PCD_ADR_W-1:0] PCD_MASK_OFF = 8'h18;

   // -------------------------------------------------------------------
   // Control register fields and reset values
   // -------------------------------------------------------------------
   localparam int PCD_ME_BIT = 3;
   localparam int PCD_SUM_BIT = 0;
   localparam int PCD_LANE0 = 0;
   localparam logic PCD_ME_RST = 1'b0;
   localparam logic [PCD_DAT_W-1:0] PCD_DAT_RST = 32'h0000_0000;

endpackage

// *** design/pcd_edge_det.sv ***
// One pin's edge detector: two samples compared, gated by the enables.
// Assumes the pin is already synchronous to the clock.
`timescale 1ns/1ps
module pcd_edge_det
   import pcd_pkg::*;
(
   input wire logic clk_i,      // System clock
   input wire logic rst_i,      // Synchronous reset, active high
   input wire logic pin_i,      // Pin level
   input wire logic rise_en_i,  // Rising edge enable
   input wire logic fall_en_i,  // Falling edge enable
   output logic rise_o,         // Raw rising edge seen
   output logic fall_o,         // Raw falling edge seen
   output logic event_o         // Enabled edge seen
);
   typedef struct packed {
      logic cur;
      logic prev;
      logic primed;
      logic loaded;
   } pcd_edge_s;

   pcd_edge_s s_q, s_d;

   // No edge is reported until two samples exist, so a pin sitting high
   // at reset release does not look like a rising edge.
   always_comb begin
      s_d = s_q;
      s_d.cur = pin_i;
      s_d.prev = s_q.cur;
      // Primed one edge after the first sample, so prev is a real sample
      s_d.loaded = 1'b1;
      s_d.primed = s_q.loaded;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rise_o = s_q.primed & s_q.cur & ~s_q.prev;
   assign fall_o = s_q.primed & ~s_q.cur & s_q.prev;
   // Either enable may be set alone or both together
   assign event_o = (rise_o & rise_en_i) | (fall_o & fall_en_i);
endmodule // pcd_edge_det

// *** design/pcd_sticky.sv ***
// Vector of sticky flags where a set beats a clear in the same cycle.
// Assumes set and clear vectors are synchronous to the clock.
`timescale 1ns/1ps
module pcd_sticky
   import pcd_pkg::*;
#(
   parameter int W = PCD_PORT_W
)
(
   input wire logic clk_i,          // System clock
   input wire logic rst_i,          // Synchronous reset, active high
   input wire logic [W-1:0] set_i,  // Set pulses
   input wire logic [W-1:0] clr_i,  // Clear pulses
   output logic [W-1:0] q_o,        // Flag state
   output logic [W-1:0] d_o         // Flag state after this edge
);
   typedef struct packed {
      logic [W-1:0] flag;
   } pcd_sticky_s;

   pcd_sticky_s s_q, s_d;

   always_comb begin
      s_d = s_q;
      s_d.flag = (s_q.flag & ~clr_i) | set_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign q_o = s_q.flag;
   assign d_o = s_d.flag;
endmodule // pcd_sticky

// *** dv/pcd_far_model.sv ***
// Far side of the pin-change block: the port pins and the sleeping core.
// Assumes the bench asks for pin levels and sleep state each cycle.
`timescale 1ns/1ps
module pcd_far_model
   import pcd_pkg::*;
#(
   parameter int W = PCD_PORT_W
)
(
   input wire logic clk_i,              // System clock
   input wire logic [W-1:0] pin_req_i,  // Wanted pin levels
   input wire logic sleep_req_i,        // Wanted sleep state
   output logic [W-1:0] port_o,         // Pin levels to the block
   output logic sleep_o                 // Core asleep
);
   // Levels change only on a clock edge, so every pulse lasts a cycle
   always_ff @(posedge clk_i) begin
      port_o <= pin_req_i;
      sleep_o <= sleep_req_i;
   end
endmodule // pcd_far_model

// *** dv/pcd_top_tb.sv ***
// Self-checking bench for the pin-change block over classic Wishbone.
// Assumes the far-side model drives the pins and the sleep input.
`timescale 1ns/1ps
module pcd_top_tb;
   import pcd_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sleep_req = 1'b0;
   logic [PCD_ADR_W-1:0] adr = '0;
   logic [PCD_SEL_W-1:0] sel = '0;
   logic [PCD_DAT_W-1:0] wdat = '0, rd;
   logic [PCD_PORT_W-1:0] pin_req = '0, port;
   logic sleep, ack, irq, wake;
   logic [PCD_DAT_W-1:0] dat_o;
   int mismatches = 0;
   int checks_done = 0;
   pcd_far_model u_pcd_far_model (.clk_i(clk), .pin_req_i(pin_req),
      .sleep_req_i(sleep_req), .port_o(port), .sleep_o(sleep));
   pcd_top u_pcd_top (.REF_CLK_I(clk), .RESET_I(rst), .PORT_I(port),
      .SLEEP_I(sleep), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
      .WB_ACK_O(ack), .IRQ_O(irq), .WAKE_O(wake));
   // -------------------------------------------------------------------
   // Clock, verdict and watchdog
   // -------------------------------------------------------------------
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic print_verdict();
      $display("Counts: %0d checks, %0d mismatches", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      print_verdict();
   end
   // -------------------------------------------------------------------
   // Bus cycles and compares
   // -------------------------------------------------------------------
   task automatic wb_cycle(input logic w, input logic [PCD_ADR_W-1:0] a,
                           input logic [PCD_DAT_W-1:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      wdat <= d;
      // Only the watchdog ends a wait for ack
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      // Data is taken at the edge where ack is seen high
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wb_write(input logic [PCD_ADR_W-1:0] a,
                           input logic [PCD_DAT_W-1:0] d);
      wb_cycle(1'b1, a, d);
   endtask
   task automatic chk_reg(input logic [PCD_ADR_W-1:0] a,
                          input logic [PCD_DAT_W-1:0] exp);
      wb_cycle(1'b0, a, '0);
      checks_done++;
      if (rd !== exp) begin
         mismatches++;
         $display("MISMATCH %0t reg %h got %h exp %h", $time, a, rd, exp);
      end
   endtask
   task automatic chk_lvl(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t level got %b exp %b", $time, got, exp);
      end
   endtask
   task automatic pins(input logic [PCD_PORT_W-1:0] v);
      @(posedge clk);
      pin_req <= v;
      repeat (4) @(posedge clk);
   endtask
   // Software clear: write back only the bits seen set, as zeros
   task automatic clear_flags();
      wb_cycle(1'b0, PCD_FLAG_OFF, '0);
      wb_write(PCD_FLAG_OFF, ~rd & 32'h0000_00FF);
      wb_write(PCD_STAT_OFF, 32'h0000_00FF);
   endtask
   // -------------------------------------------------------------------
   // Tests
   // -------------------------------------------------------------------
   logic [PCD_ADR_W-1:0] offs [7] = '{PCD_CTRL_OFF, PCD_RISE_OFF,
      PCD_FALL_OFF, PCD_FLAG_OFF, PCD_STAT_OFF, PCD_MASK_OFF, 8'h1C};
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      foreach (offs[i]) chk_reg(offs[i], PCD_DAT_RST);
      wb_write(PCD_RISE_OFF, 32'h0000_0055);
      wb_write(PCD_FALL_OFF, 32'h0000_0033);
      wb_write(PCD_MASK_OFF, 32'h0000_00FF);
      // Pins 3 and 7 have no enable and must never flag
      pins(8'hFF);
      chk_reg(PCD_FLAG_OFF, 32'h0000_0055);
      chk_reg(PCD_CTRL_OFF, 32'h0000_0001);
      chk_lvl(irq, 1'b0);
      chk_reg(PCD_PINS_OFF, 32'h0000_00FF);
      chk_reg(PCD_STAT_OFF, 32'h0000_0055);
      wb_write(PCD_FLAG_OFF, 32'h0000_00FF);
      chk_reg(PCD_FLAG_OFF, 32'h0000_0055);
      wb_write(PCD_CTRL_OFF, 32'h0000_0008);
      repeat (2) @(posedge clk);
      chk_lvl(irq, 1'b1);
      clear_flags();
      chk_reg(PCD_FLAG_OFF, 32'h0000_0000);
      chk_reg(PCD_CTRL_OFF, 32'h0000_0008);
      repeat (2) @(posedge clk);
      chk_lvl(irq, 1'b0);
      pins(8'h00);
      chk_reg(PCD_FLAG_OFF, 32'h0000_0033);
      chk_reg(PCD_STAT_OFF, 32'h0000_0033);
      chk_lvl(irq, 1'b1);
      clear_flags();
      pins(8'h01);
      // Falling edge on pin 0 lands on the same edge as its clear
      @(posedge clk);
      pin_req <= 8'h00;
      wb_write(PCD_FLAG_OFF, 32'h0000_0000);
      chk_reg(PCD_FLAG_OFF, 32'h0000_0001);
      clear_flags();
      // Pin 4 masked: its event is recorded but raises nothing
      wb_write(PCD_MASK_OFF, 32'h0000_00EF);
      chk_reg(PCD_MASK_OFF, 32'h0000_00EF);
      pins(8'h10);
      chk_reg(PCD_STAT_OFF, 32'h0000_0010);
      chk_lvl(irq, 1'b0);
      wb_write(PCD_MASK_OFF, 32'h0000_00FF);
      repeat (2) @(posedge clk);
      chk_lvl(irq, 1'b1);
      pins(8'h00);
      clear_flags();
      wb_write(PCD_CTRL_OFF, 32'h0000_0000);
      sleep_req <= 1'b1;
      pins(8'h01);
      chk_lvl(wake, 1'b0);
      clear_flags();
      wb_write(PCD_CTRL_OFF, 32'h0000_0008);
      pins(8'h00);
      chk_lvl(wake, 1'b1);
      chk_reg(PCD_FLAG_OFF, 32'h0000_0001);
      sleep_req <= 1'b0;
      print_verdict();
   end
endmodule // pcd_top_tb
